//--- verilog/cmd_decoder_pkg.sv
// Constants for the configuration-command decoder: byte codes, frame limits, FSM states.
// Assumes a byte-wide UART engine and a register map outside, all on one clock.
// Contract
// - A byte at or above 0x80 may arrive as escape 0xFE plus value minus 0x80
// - Escape decoding applies alike to the address byte and the value byte
// - Single write frame sizes are 0x02, 0x03 or 0x04 by escapes used
// - A valid write to writable registers is answered with acknowledge 0x06
// - Write to read-only or missing register: answer 0x15, change nothing
// - Bytes 0x00 to 0xEF are taken unescaped at face value
// - After an escape byte, bit 7 of the next data byte is inverted
// - One decoded byte means a read of that byte with bit 7 inverted
// - Two escapes cancel, unless the next byte is 0xF0 to 0xFF
// - Several decoded bytes mean a write: register number, then data, 32 at most
// - Size byte counts field bytes including escapes; no 0xFF in either
// - Serial bytes are commands only while the configuration-select line is low
// - Valid read answers 0x06, register number, raw value; invalid read answers 0x15
// - Link bytes are 8N1 at the configured baud rate
package cmd_decoder_pkg;

    localparam logic [7:0] HEADER_BYTE = 8'hFF;
    localparam logic [7:0] ESCAPE_BYTE = 8'hFE;
    localparam logic [7:0] RESERVED_LO = 8'hF0;
    localparam logic [7:0] BIT7_MASK = 8'h80;
    localparam logic [7:0] ACK_BYTE = 8'h06;
    localparam logic [7:0] COMMAND_REJECTED_BYTE = 8'h15;
    localparam logic [7:0] ONE_BYTE = 8'h01;
    localparam logic [7:0] ZERO_BYTE = 8'h00;

    localparam int MAX_DECODED = 32;
    localparam logic [5:0] MAX_DECODED_W = 6'h20;
    localparam logic [5:0] ONE_IDX = 6'h01;
    localparam logic [1:0] DEPTH_NONE = 2'h0;
    localparam logic [1:0] DEPTH_ONE = 2'h1;
    localparam logic [1:0] DEPTH_TWO = 2'h2;
    localparam logic [1:0] RESP_ONE = 2'h1;
    localparam logic [1:0] RESP_THREE = 2'h3;

    typedef enum logic [8:0] {
        ST_IDLE  = 9'h001,
        ST_SIZE  = 9'h002,
        ST_FIELD = 9'h004,
        ST_DRAIN = 9'h008,
        ST_EVAL  = 9'h010,
        ST_READ  = 9'h020,
        ST_CHECK = 9'h040,
        ST_WRITE = 9'h080,
        ST_RESP  = 9'h100
    } dec_state_e;

    // True for the raw codes kept back for future use
    function automatic logic is_reserved(input logic [7:0] b);
        is_reserved = (b >= RESERVED_LO) && (b < ESCAPE_BYTE);
    endfunction : is_reserved

endpackage : cmd_decoder_pkg

//--- verilog/resp_if.sv
// Carrier between the frame controller and the response sender.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface resp_if;
    logic load;
    logic [1:0] count;
    logic [7:0] byte0;
    logic [7:0] byte1;
    logic [7:0] byte2;
    logic busy;
    modport source (output load, output count, output byte0, output byte1, output byte2,
                    input busy);
    modport sink (input load, input count, input byte0, input byte1, input byte2,
                  output busy);
endinterface : resp_if
`default_nettype wire

//--- verilog/escape_decoder.sv
// Undoes the escape encoding of one command field, byte by byte.
// Assumes header bytes are filtered out by the caller and clear_i marks a new frame.
`timescale 1ns/1ps
`default_nettype none
module escape_decoder (
    input wire logic core_clk_i,      // Core clock
    input wire logic rst_b_i,         // Async reset, active low
    input wire logic clear_i,         // Start of a new field
    input wire logic [7:0] byte_i,    // Raw field byte
    input wire logic valid_i,         // Raw byte strobe
    output logic [7:0] dec_byte_o,    // Decoded byte
    output logic dec_valid_o,         // Decoded byte strobe
    output logic reserved_o,          // Raw reserved code seen
    output logic pending_o            // Escape still waiting for its byte
);
    import cmd_decoder_pkg::*;

    logic [1:0] depth_q;
    logic [1:0] depth_d;
    logic [7:0] dec_d;
    logic emit;
    wire is_esc = (byte_i == ESCAPE_BYTE);
    wire is_rsv = is_reserved(byte_i);

    always_comb begin
        depth_d = depth_q;
        dec_d = byte_i;
        emit = 1'b0;
        if (valid_i && !is_rsv) begin
            if (is_esc && depth_q == DEPTH_TWO) begin
                // Third escape: the first applies to the second, the third stays pending
                dec_d = ESCAPE_BYTE ^ BIT7_MASK;
                emit = 1'b1;
                depth_d = DEPTH_ONE;
            end else if (is_esc) begin
                depth_d = depth_q + DEPTH_ONE;
            end else begin
                dec_d = (depth_q == DEPTH_ONE) ? (byte_i ^ BIT7_MASK) : byte_i;
                emit = 1'b1;
                depth_d = DEPTH_NONE;
            end
        end else if (valid_i) begin
            depth_d = DEPTH_NONE;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            depth_q <= DEPTH_NONE;
            dec_byte_o <= ZERO_BYTE;
            dec_valid_o <= 1'b0;
            reserved_o <= 1'b0;
        end else begin
            depth_q <= clear_i ? DEPTH_NONE : depth_d;
            dec_byte_o <= dec_d;
            dec_valid_o <= emit && !clear_i;
            reserved_o <= valid_i && is_rsv && !clear_i;
        end
    end

    assign pending_o = (depth_q != DEPTH_NONE);
endmodule : escape_decoder
`default_nettype wire

//--- verilog/response_sender.sv
// Sends a loaded answer of one or three bytes to the UART transmitter.
// Assumes the transmitter takes a byte when tx_valid_o and tx_ready_i are both high.
`timescale 1ns/1ps
`default_nettype none
module response_sender (
    input wire logic core_clk_i,      // Core clock
    input wire logic rst_b_i,         // Async reset, active low
    resp_if.sink resp,                // Answer from the controller
    output logic [7:0] tx_byte_o,     // Byte to transmitter
    output logic tx_valid_o,          // Byte offered
    input wire logic tx_ready_i       // Transmitter takes byte
);
    import cmd_decoder_pkg::*;

    logic [1:0] left_q;
    logic [7:0] next1_q;
    logic [7:0] next2_q;
    wire take = tx_valid_o && tx_ready_i;

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            left_q <= 2'h0;
            tx_byte_o <= ZERO_BYTE;
            next1_q <= ZERO_BYTE;
            next2_q <= ZERO_BYTE;
        end else if (resp.load && !resp.busy) begin
            left_q <= resp.count;
            tx_byte_o <= resp.byte0;
            next1_q <= resp.byte1;
            next2_q <= resp.byte2;
        end else if (take) begin
            left_q <= left_q - RESP_ONE;
            tx_byte_o <= next1_q;
            next1_q <= next2_q;
        end
    end

    assign tx_valid_o = (left_q != 2'h0);
    assign resp.busy = tx_valid_o;
endmodule : response_sender
`default_nettype wire

//--- verilog/register_command_decoder.sv
// Frame controller for configuration commands arriving from the host UART.
// Assumes the UART engine and register map share core_clk_i; the select line is a pin.
`timescale 1ns/1ps
`default_nettype none
module register_command_decoder (
    input wire logic core_clk_i,      // Core clock, 250 MHz
    input wire logic rst_b_i,         // Async reset, active low
    input wire logic [7:0] rx_byte_i, // Byte from UART receiver, 8N1
    input wire logic rx_valid_i,      // Received byte strobe
    input wire logic cfg_select_b_i,  // Low: bytes are commands
    output logic [7:0] payload_byte_o,// Byte meant for transmission
    output logic payload_valid_o,     // Payload byte strobe
    output logic [7:0] reg_addr_o,    // Register number
    output logic [7:0] reg_wdata_o,   // Value to write
    output logic reg_wr_o,            // Write strobe
    output logic reg_rd_o,            // Read strobe
    input wire logic [7:0] reg_rdata_i, // Value of reg_addr_o
    input wire logic reg_readable_i,  // reg_addr_o exists
    input wire logic reg_writable_i,  // reg_addr_o may be written
    output logic [7:0] tx_byte_o,     // Answer byte to UART transmitter
    output logic tx_valid_o,          // Answer byte offered
    input wire logic tx_ready_i       // Transmitter takes byte
);
    import cmd_decoder_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Select line synchroniser and receive qualifiers

    logic sel_meta_q;
    logic sel_q;

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sel_meta_q <= 1'b1;
            sel_q <= 1'b1;
        end else begin
            sel_meta_q <= cfg_select_b_i;
            sel_q <= sel_meta_q;
        end
    end

    dec_state_e st_q;
    dec_state_e st_d;
    logic [7:0] size_q;
    logic [7:0] rcnt_q;
    logic [5:0] nbytes_q;
    logic [5:0] idx_q;
    logic err_q;
    logic [7:0] addr_q;
    logic [7:0] wdata_q;
    logic [7:0] buf_q [MAX_DECODED];
    logic [1:0] rcount_q;
    logic [7:0] rb0_q;
    logic [7:0] rb1_q;
    logic [7:0] rb2_q;
    logic [7:0] dec_byte;
    logic dec_valid;
    logic dec_rsv;
    logic dec_pend;

    wire rx_cmd = rx_valid_i && !sel_q;
    wire rx_hdr = rx_cmd && (rx_byte_i == HEADER_BYTE);
    wire in_frame = (st_q == ST_IDLE) || (st_q == ST_SIZE) || (st_q == ST_FIELD);
    wire restart = in_frame && rx_hdr;
    wire abort = sel_q && ((st_q == ST_SIZE) || (st_q == ST_FIELD));
    wire size_zero = (rx_byte_i == ZERO_BYTE);
    wire last_raw = (8'(rcnt_q + ONE_BYTE) == size_q);
    wire field_take = rx_cmd && !rx_hdr && (st_q == ST_FIELD);
    wire overflow = dec_valid && (nbytes_q == MAX_DECODED_W);
    wire last_idx = (idx_q == 6'(nbytes_q - ONE_IDX));
    wire [7:0] next_wdata = buf_q[5'(idx_q + ONE_IDX)];

    ////////////////////////////////////////////////////////////////////////////
    // Escape decoding of the field

    escape_decoder u_escape (
        .core_clk_i (core_clk_i),
        .rst_b_i (rst_b_i),
        .clear_i (restart || abort),
        .byte_i (rx_byte_i),
        .valid_i (field_take),
        .dec_byte_o (dec_byte),
        .dec_valid_o (dec_valid),
        .reserved_o (dec_rsv),
        .pending_o (dec_pend)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Frame sequencing

    resp_if resp ();

    always_comb begin
        st_d = st_q;
        unique case (st_q)
            ST_IDLE: begin
                if (rx_hdr) st_d = ST_SIZE;
            end
            ST_SIZE: begin
                if (rx_hdr) st_d = ST_SIZE;
                else if (rx_cmd && size_zero) st_d = ST_EVAL;
                else if (rx_cmd) st_d = ST_FIELD;
            end
            ST_FIELD: begin
                if (rx_hdr) st_d = ST_SIZE;
                else if (field_take && last_raw) st_d = ST_DRAIN;
            end
            ST_DRAIN: st_d = ST_EVAL;
            ST_EVAL: begin
                if (err_q || nbytes_q == 6'h00) st_d = ST_RESP;
                else if (nbytes_q == ONE_IDX) st_d = ST_READ;
                else st_d = ST_CHECK;
            end
            ST_READ: st_d = ST_RESP;
            ST_CHECK: begin
                if (!reg_writable_i) st_d = ST_RESP;
                else if (last_idx) st_d = ST_WRITE;
            end
            ST_WRITE: begin
                if (last_idx) st_d = ST_RESP;
            end
            ST_RESP: begin
                if (!resp.busy) st_d = ST_IDLE;
            end
        endcase
        if (abort) st_d = ST_IDLE;
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) st_q <= ST_IDLE;
        else st_q <= st_d;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Field counting, decoded byte store and error tracking

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            size_q <= ZERO_BYTE;
            rcnt_q <= ZERO_BYTE;
            nbytes_q <= 6'h00;
            err_q <= 1'b0;
        end else if (restart) begin
            rcnt_q <= ZERO_BYTE;
            nbytes_q <= 6'h00;
            err_q <= 1'b0;
        end else begin
            if (st_q == ST_SIZE && rx_cmd) begin
                size_q <= rx_byte_i;
                err_q <= size_zero;
            end
            if (field_take) rcnt_q <= 8'(rcnt_q + ONE_BYTE);
            if (dec_valid && !overflow) nbytes_q <= 6'(nbytes_q + ONE_IDX);
            // A dangling escape means the size did not match the field
            if (dec_rsv || overflow || (st_q == ST_DRAIN && dec_pend)) err_q <= 1'b1;
        end
    end

    // Storage needs no reset: only entries below nbytes_q ever reach a read or write strobe
    always_ff @(posedge core_clk_i) begin
        if (dec_valid && !overflow) buf_q[nbytes_q[4:0]] <= dec_byte;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register access: check every target first so a refused write changes nothing

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            addr_q <= ZERO_BYTE;
            wdata_q <= ZERO_BYTE;
            idx_q <= 6'h00;
        end else if (st_q == ST_EVAL) begin
            addr_q <= (nbytes_q == ONE_IDX) ? (buf_q[0] ^ BIT7_MASK) : buf_q[0];
            idx_q <= ONE_IDX;
        end else if (st_q == ST_CHECK && reg_writable_i) begin
            addr_q <= last_idx ? buf_q[0] : 8'(addr_q + ONE_BYTE);
            idx_q <= last_idx ? ONE_IDX : 6'(idx_q + ONE_IDX);
            wdata_q <= buf_q[1];
        end else if (st_q == ST_WRITE) begin
            addr_q <= 8'(addr_q + ONE_BYTE);
            idx_q <= 6'(idx_q + ONE_IDX);
            wdata_q <= next_wdata;
        end
    end

    assign reg_addr_o = addr_q;
    assign reg_wdata_o = wdata_q;
    assign reg_wr_o = (st_q == ST_WRITE);
    assign reg_rd_o = (st_q == ST_READ);

    ////////////////////////////////////////////////////////////////////////////
    // Answer composition

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rcount_q <= RESP_ONE;
            rb0_q <= COMMAND_REJECTED_BYTE;
            rb1_q <= ZERO_BYTE;
            rb2_q <= ZERO_BYTE;
        end else begin
            if (st_q == ST_EVAL) begin
                rcount_q <= RESP_ONE;
                rb0_q <= COMMAND_REJECTED_BYTE;
            end
            if (st_q == ST_READ && reg_readable_i) begin
                rcount_q <= RESP_THREE;
                rb0_q <= ACK_BYTE;
                rb1_q <= addr_q;
                rb2_q <= reg_rdata_i; // Raw, never escaped
            end
            if (st_q == ST_CHECK && !reg_writable_i) rb0_q <= COMMAND_REJECTED_BYTE;
            if (st_q == ST_WRITE && last_idx) rb0_q <= ACK_BYTE;
        end
    end

    assign resp.load = (st_q == ST_RESP);
    assign resp.count = rcount_q;
    assign resp.byte0 = rb0_q;
    assign resp.byte1 = rb1_q;
    assign resp.byte2 = rb2_q;

    response_sender u_sender (
        .core_clk_i (core_clk_i),
        .rst_b_i (rst_b_i),
        .resp (resp),
        .tx_byte_o (tx_byte_o),
        .tx_valid_o (tx_valid_o),
        .tx_ready_i (tx_ready_i)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Payload pass-through while the select line is high

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            payload_byte_o <= ZERO_BYTE;
            payload_valid_o <= 1'b0;
        end else begin
            payload_byte_o <= rx_byte_i;
            payload_valid_o <= rx_valid_i && sel_q;
        end
    end
endmodule : register_command_decoder
`default_nettype wire

//--- bench/register_command_decoder_monitor.sv
// Checker: timing and value relations at the decoder's top ports.
// Assumes readable and writable flags follow reg_addr_o in the same cycle.
`timescale 1ns/1ps
`default_nettype none
module register_command_decoder_monitor
    import cmd_decoder_pkg::*;
(
    input wire logic core_clk_i,           // Clock
    input wire logic rst_b_i,              // Reset, active low
    input wire logic [7:0] rx_byte_i,      // Received byte
    input wire logic rx_valid_i,           // Received strobe
    input wire logic cfg_select_b_i,       // Command select pin
    input wire logic [7:0] payload_byte_o, // Payload byte
    input wire logic payload_valid_o,      // Payload strobe
    input wire logic [7:0] reg_addr_o,     // Register number
    input wire logic reg_wr_o,             // Write strobe
    input wire logic reg_rd_o,             // Read strobe
    input wire logic reg_readable_i,       // Register exists
    input wire logic reg_writable_i,       // Register writable
    input wire logic [7:0] tx_byte_o,      // Answer byte
    input wire logic tx_valid_o,           // Answer offered
    input wire logic tx_ready_i            // Answer taken
);
    logic [1:0] up_q;
    // The select sync sits in payload mode for two edges after reset; skip that span
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            up_q <= 2'h0;
        end else if (up_q != 2'h3) begin
            up_q <= up_q + 2'h1;
        end
    end
    default clocking dc @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);
    ////////////////////////////////////////////////////////////////////////////////
    property p_wr_ack; reg_wr_o |-> ##[1:40] (tx_valid_o && tx_byte_o == ACK_BYTE); endproperty
    a_wr_ack: assert property (p_wr_ack) else $error("write without acknowledge");
    property p_wr_ok; reg_wr_o |-> reg_writable_i; endproperty
    a_wr_ok: assert property (p_wr_ok) else $error("write to protected register");
    property p_wr_step;
        reg_wr_o && $past(reg_wr_o) |-> reg_addr_o == $past(reg_addr_o) + 8'h01;
    endproperty
    a_wr_step: assert property (p_wr_step) else $error("data bytes not consecutive");
    property p_rd_ack;
        reg_rd_o && reg_readable_i |-> ##[1:6] (tx_valid_o && tx_byte_o == ACK_BYTE);
    endproperty
    a_rd_ack: assert property (p_rd_ack) else $error("read without acknowledge");
    property p_rd_rej;
        reg_rd_o && !reg_readable_i |-> ##[1:6] (tx_valid_o && tx_byte_o == COMMAND_REJECTED_BYTE);
    endproperty
    a_rd_rej: assert property (p_rd_rej) else $error("bad read not rejected");
    property p_rd_pulse; reg_rd_o |=> !reg_rd_o && !reg_wr_o; endproperty
    a_rd_pulse: assert property (p_rd_pulse) else $error("read strobe too long");
    property p_tx_hold; tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_byte_o); endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("answer byte dropped");
    property p_pay;
        cfg_select_b_i [*3] ##0 rx_valid_i |=> payload_valid_o && payload_byte_o == $past(rx_byte_i);
    endproperty
    a_pay: assert property (p_pay) else $error("payload byte lost");
    property p_no_pay;
        (!cfg_select_b_i) [*3] ##0 (rx_valid_i && up_q == 2'h3) |=> !payload_valid_o;
    endproperty
    a_no_pay: assert property (p_no_pay) else $error("command byte sent as payload");
    c_write: cover property (reg_wr_o);
    c_read: cover property (reg_rd_o && reg_readable_i);
    c_reject: cover property (tx_valid_o && tx_byte_o == COMMAND_REJECTED_BYTE);
endmodule : register_command_decoder_monitor

bind register_command_decoder register_command_decoder_monitor register_command_decoder_monitor_i (
    .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .rx_byte_i(rx_byte_i), .rx_valid_i(rx_valid_i),
    .cfg_select_b_i(cfg_select_b_i), .payload_byte_o(payload_byte_o),
    .payload_valid_o(payload_valid_o), .reg_addr_o(reg_addr_o), .reg_wr_o(reg_wr_o),
    .reg_rd_o(reg_rd_o), .reg_readable_i(reg_readable_i), .reg_writable_i(reg_writable_i),
    .tx_byte_o(tx_byte_o), .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i)
);
`default_nettype wire

//--- bench/host_model.sv
// Host-side model: frames commands onto the decoder's byte input, takes answers.
// Assumes its tasks are entered at a rising edge of core_clk_i.
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input wire logic core_clk_i,      // Clock
    output logic [7:0] rx_byte_o,     // Byte to decoder
    output logic rx_valid_o,          // Byte strobe
    input wire logic [7:0] tx_byte_i, // Answer byte
    input wire logic tx_valid_i,      // Answer offered
    output logic tx_ready_o           // Answer taken
);
    logic [7:0] got_q[$];
    logic slow;
    logic [1:0] ph_q;
    initial begin
        rx_byte_o = 8'h00;
        rx_valid_o = 1'b0;
        slow = 1'b0;
        ph_q = 2'h0;
    end
    // Slow mode takes one byte in four cycles, so answers must stand meanwhile
    assign tx_ready_o = !slow || ph_q == 2'h3;
    always @(posedge core_clk_i) begin
        ph_q <= ph_q + 2'h1;
        if (tx_valid_i && tx_ready_o) begin
            got_q.push_back(tx_byte_i);
        end
    end
    function automatic void encode(input logic [7:0] raw[$], output logic [7:0] f[$]);
        f = {};
        foreach (raw[k]) begin
            if (raw[k] >= 8'hF0) begin
                f.push_back(8'hFE);
                f.push_back(raw[k] & 8'h7F);
            end else begin
                f.push_back(raw[k]);
            end
        end
        f.push_front(8'(f.size()));
        f.push_front(8'hFF);
    endfunction : encode
    task automatic send_frame(input logic [7:0] f[$]);
        foreach (f[k]) begin
            rx_byte_o <= f[k];
            rx_valid_o <= 1'b1;
            @(posedge core_clk_i);
        end
        // Idle line shows the inverse so a stale byte never looks current
        rx_byte_o <= ~rx_byte_o;
        rx_valid_o <= 1'b0;
    endtask : send_frame
endmodule : host_model
`default_nettype wire

//--- bench/register_command_decoder_tb.sv
// Testbench for the command decoder: table of frames, then hand-written cases.
// Assumes the host model drives the byte input and takes every answer byte.
`timescale 1ns/1ps
`default_nettype none
module register_command_decoder_tb;
    import cmd_decoder_pkg::*;
    typedef struct { logic [63:0] f; int n; logic [23:0] r; int nr; } row_s;
    logic core_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic cfg_select_b_i = 1'b0;
    logic [7:0] rx_byte_i, payload_byte_o, reg_addr_o, reg_wdata_o, tx_byte_o, reg_rdata_i;
    logic rx_valid_i, payload_valid_o, reg_wr_o, reg_rd_o, reg_readable_i, reg_writable_i;
    logic tx_valid_o, tx_ready_i;
    logic [7:0] mem[256];
    logic [7:0] pay_last;
    int pay_cnt = 0;
    int miscompares = 0;
    int checks = 0;
    row_s rows[22] = '{
        '{64'hFF021055, 4, 24'h06, 1},
        '{64'hFF0310FE03, 5, 24'h06, 1},
        '{64'hFF03FE0301, 5, 24'h06, 1},
        '{64'hFF04FE05FE7F, 6, 24'h06, 1},
        '{64'hFF021AC0, 4, 24'h06, 1},
        '{64'hFF023411, 4, 24'h15, 1},
        '{64'hFF02C711, 4, 24'h15, 1},
        '{64'hFF0103, 3, 24'h068301, 3},
        '{64'hFF0105, 3, 24'h0685FF, 3},
        '{64'hFF01B4, 3, 24'h06345A, 3},
        '{64'hFF04FEFEFE30, 6, 24'h06, 1},
        '{64'hFF02FE7E, 4, 24'h067EB0, 3},
        '{64'hFF03FEFE13, 5, 24'h06935A, 3},
        '{64'hFF0147, 3, 24'h15, 1},
        '{64'hFF02F310, 4, 24'h15, 1},
        '{64'hFF0210FE, 4, 24'h15, 1},
        '{64'hFF00, 2, 24'h15, 1},
        '{64'hFF0420010203, 6, 24'h06, 1},
        '{64'hFF01A1, 3, 24'h062102, 3},
        '{64'hFF0310FF021122, 7, 24'h06, 1},
        '{64'hFF0191, 3, 24'h061122, 3},
        '{64'hFF0190, 3, 24'h061083, 3}
    };
    always #2 core_clk_i = ~core_clk_i;
    // Register map: 0xC0 and up missing, 0x30..0x3F read-only
    assign reg_rdata_i = mem[reg_addr_o];
    assign reg_readable_i = reg_addr_o < 8'hC0;
    assign reg_writable_i = reg_readable_i && reg_addr_o[7:4] != 4'h3;
    always @(posedge core_clk_i) begin
        if (reg_wr_o) begin
            mem[reg_addr_o] <= reg_wdata_o;
        end
        if (payload_valid_o) begin
            pay_cnt++;
            pay_last <= payload_byte_o;
        end
    end
    register_command_decoder register_command_decoder_i (
        .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .rx_byte_i(rx_byte_i), .rx_valid_i(rx_valid_i),
        .cfg_select_b_i(cfg_select_b_i), .payload_byte_o(payload_byte_o),
        .payload_valid_o(payload_valid_o), .reg_addr_o(reg_addr_o), .reg_wdata_o(reg_wdata_o),
        .reg_wr_o(reg_wr_o), .reg_rd_o(reg_rd_o), .reg_rdata_i(reg_rdata_i),
        .reg_readable_i(reg_readable_i), .reg_writable_i(reg_writable_i),
        .tx_byte_o(tx_byte_o), .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i)
    );
    host_model host_model_i (
        .core_clk_i(core_clk_i), .rx_byte_o(rx_byte_i), .rx_valid_o(rx_valid_i),
        .tx_byte_i(tx_byte_o), .tx_valid_i(tx_valid_o), .tx_ready_o(tx_ready_i)
    );
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic end_sim();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_sim
    // Settles 8 cycles after the last answer byte so a surplus byte is caught
    task automatic run_q(input logic [7:0] q[$], input logic [23:0] r, input int nr);
        int w;
        host_model_i.got_q.delete();
        host_model_i.send_frame(q);
        w = 0;
        while (host_model_i.got_q.size() < nr && w < 300) begin
            @(posedge core_clk_i);
            w++;
        end
        repeat (8) @(posedge core_clk_i);
        check(32'(host_model_i.got_q.size()), 32'(nr));
        for (int k = 0; k < nr; k++) begin
            check({24'h0, host_model_i.got_q[k]}, {24'h0, r[8*(nr-1-k) +: 8]});
        end
    endtask : run_q
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [7:0] q[$];
        foreach (mem[i]) mem[i] = 8'h5A;
        repeat (5) @(posedge core_clk_i);
        rst_b_i <= 1'b1;
        repeat (4) @(posedge core_clk_i);
        foreach (rows[i]) begin
            host_model_i.slow <= (i >= 12);
            q = {};
            for (int k = 0; k < rows[i].n; k++) q.push_back(rows[i].f[8*(rows[i].n-1-k) +: 8]);
            run_q(q, rows[i].r, rows[i].nr);
            $display("row %0d done", i);
        end
        // 33 decoded bytes overflow; 32 is the limit
        q = {8'hFF, 8'h21};
        repeat (33) q.push_back(8'h44);
        run_q(q, 24'h15, 1);
        q[1] = 8'h20;
        void'(q.pop_back());
        run_q(q, 24'h06, 1);
        host_model_i.encode({8'h40, 8'hF5, 8'h12}, q);
        run_q(q, 24'h06, 1);
        run_q({8'hFF, 8'h01, 8'hC0}, 24'h0640F5, 3);
        $display("encoded write done");
        cfg_select_b_i <= 1'b1;
        repeat (3) @(posedge core_clk_i);
        pay_cnt = 0;
        run_q({8'hFF, 8'h02, 8'h10, 8'h66}, 24'h0, 0);
        check(32'(pay_cnt), 32'd4);
        check({24'h0, pay_last}, 32'h66);
        // Select rises in mid-frame: the partial command must vanish unanswered
        cfg_select_b_i <= 1'b0;
        repeat (3) @(posedge core_clk_i);
        host_model_i.send_frame({8'hFF, 8'h03, 8'h10});
        @(posedge core_clk_i);
        cfg_select_b_i <= 1'b1;
        repeat (4) @(posedge core_clk_i);
        cfg_select_b_i <= 1'b0;
        repeat (3) @(posedge core_clk_i);
        check(32'(host_model_i.got_q.size()), 32'd0);
        run_q({8'hFF, 8'h01, 8'h90}, 24'h061083, 3);
        $display("select case done");
        // Reset lands before the write, so only the resend may carry it out
        host_model_i.send_frame({8'hFF, 8'h02, 8'h10, 8'h77});
        repeat (2) @(posedge core_clk_i);
        rst_b_i <= 1'b0;
        repeat (2) @(posedge core_clk_i);
        check({28'h0, tx_valid_o, reg_wr_o, reg_rd_o, payload_valid_o}, 32'h0);
        check({24'h0, tx_byte_o}, 32'h0);
        rst_b_i <= 1'b1;
        repeat (5) @(posedge core_clk_i);
        run_q({8'hFF, 8'h02, 8'h10, 8'h77}, 24'h06, 1);
        check({24'h0, mem[8'h10]}, 32'h77);
        $display("reset case done");
        end_sim();
    end
    initial begin
        repeat (20000) @(posedge core_clk_i);
        miscompares++;
        end_sim();
    end
endmodule : register_command_decoder_tb
`default_nettype wire
